/* File: hdl/emss_defs.svh */
// timing counts, field widths and reset values for the mac scheduling and shaping block
// assumes the includer compiles it once per unit; guarded against double inclusion
`ifndef EMSS_DEFS_SVH
`define EMSS_DEFS_SVH
`define EMSS_CLK_PERIOD_NS 40
`define EMSS_RST_SEQ_NS 400
`define EMSS_RST_SEQ_CYCLES ((`EMSS_RST_SEQ_NS + `EMSS_CLK_PERIOD_NS - 1) / `EMSS_CLK_PERIOD_NS)
`define EMSS_MIN_LEFTOVER_PTP 8
`define EMSS_GCL_DEPTH 8
`define EMSS_TIME_W 32
`define EMSS_GATE_W 8
`define EMSS_CREDIT_W 32
`define EMSS_IPG_BYTES 12
`define EMSS_FIFO_DEPTH 32
`define EMSS_GATES_RESET 8'hff
`endif

/* File: hdl/emss_pkg.sv */
// types shared by the scheduling and shaping block
// assumes emss_defs.svh is compiled alongside
package emss_pkg;
  typedef enum logic [1:0] {
    EMSS_RST_IDLE,
    EMSS_RST_CORE,
    EMSS_RST_WAIT_LINK
  } emss_rst_state_t;
  typedef enum logic [1:0] {
    EMSS_GCL_OFF,
    EMSS_GCL_WAIT_BASE,
    EMSS_GCL_RUN,
    EMSS_GCL_HOLD
  } emss_gcl_state_t;
  typedef enum logic [1:0] {
    EMSS_TX_IDLE,
    EMSS_TX_FRAME,
    EMSS_TX_GAP
  } emss_tx_state_t;
endpackage

/* File: hdl/emss_fifo.sv */
// synchronous fifo with valid and ready on both sides
// assumes one clock and an asynchronous active low reset
module emss_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // fill side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // drain side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;
  assign in_ready_out = (count != DEPTH[AW:0]);
  assign out_valid_out = (count != '0);
  assign out_data_out = mem[rd_ptr];
  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

/* File: hdl/emss_top.sv */
// soft reset sequencing, gate control list scheduler and credit based shaper of a mac transmit path
// assumes ptp time arrives in the core clock domain as a nanosecond counter; the link phy sits after tx bytes
`include "emss_defs.svh"

module emss_top #(
  parameter int DEPTH = `EMSS_GCL_DEPTH,
  parameter int TW = `EMSS_TIME_W,
  parameter int GW = `EMSS_GATE_W,
  parameter int CW = `EMSS_CREDIT_W,
  parameter int FIFO_DEPTH = `EMSS_FIFO_DEPTH
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // soft reset control
  input wire logic soft_reset_set_in,
  input wire logic rmii_mode_in,
  input wire logic port_select_bit_in,
  input wire logic speed_select_bit_in,
  output logic soft_reset_bit_out,
  output logic mac_core_reset_out,
  // scheduler configuration
  input wire logic scheduled_traffic_enh_in,
  input wire logic [TW-1:0] base_time_value_in,
  input wire logic [TW-1:0] cycle_time_value_in,
  input wire logic [$clog2(DEPTH+1)-1:0] gcl_length_in,
  input wire logic gcl_wr_in,
  input wire logic [$clog2(DEPTH)-1:0] gcl_wr_addr_in,
  input wire logic [TW-1:0] gate_row_interval_in,
  input wire logic [GW-1:0] gcl_gates_in,
  input wire logic [TW-1:0] ptp_time_in,
  // scheduler status
  output logic [GW-1:0] gate_state_out,
  output logic [TW-1:0] loop_start_out,
  output logic [TW-1:0] gcl_exec_time_out,
  output logic [15:0] loop_count_out,
  // shaper configuration and status
  input wire logic [CW-1:0] idle_slope_in,
  input wire logic [CW-1:0] send_slope_in,
  output logic signed [CW-1:0] credit_out,
  // transmit queue stream, last marks the final fcs byte
  input wire logic tq_valid_in,
  input wire logic [7:0] tq_data_in,
  input wire logic tq_last_in,
  output logic tq_ready_out,
  // transmit bytes toward the phy side
  output logic tx_valid_out,
  output logic [7:0] tx_data_out,
  output logic tx_last_out,
  input wire logic tx_ready_in
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);
  localparam logic [7:0] RST_CYC = 8'(`EMSS_RST_SEQ_CYCLES);
  localparam logic [TW-1:0] MIN_LEFT = TW'(`EMSS_MIN_LEFTOVER_PTP);
  localparam logic [3:0] IPG = 4'(`EMSS_IPG_BYTES);

  // soft reset: the link half of the sequence needs the port or the speed bit rewritten in rmii mode
  emss_pkg::emss_rst_state_t rst_state;
  logic [7:0] rst_cnt;
  logic ps_q;
  logic fes_q;
  logic link_seen;
  wire link_cfg_written = (port_select_bit_in != ps_q) || (speed_select_bit_in != fes_q);
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_state <= emss_pkg::EMSS_RST_IDLE;
      rst_cnt <= '0;
      ps_q <= 1'b0;
      fes_q <= 1'b0;
      link_seen <= 1'b0;
    end else begin
      ps_q <= port_select_bit_in;
      fes_q <= speed_select_bit_in;
      // a port or speed write during the core half is kept, so an early write cannot leave the bit stuck
      link_seen <= (rst_state != emss_pkg::EMSS_RST_IDLE) && (link_seen || link_cfg_written);
      case (rst_state)
        emss_pkg::EMSS_RST_IDLE: begin
          if (soft_reset_set_in) begin
            rst_state <= emss_pkg::EMSS_RST_CORE;
            rst_cnt <= RST_CYC;
          end
        end
        emss_pkg::EMSS_RST_CORE: begin
          if (rst_cnt > 8'h01) begin
            rst_cnt <= rst_cnt - 8'h01;
          end else if (rmii_mode_in) begin
            rst_state <= emss_pkg::EMSS_RST_WAIT_LINK;
          end else begin
            rst_state <= emss_pkg::EMSS_RST_IDLE;
          end
        end
        emss_pkg::EMSS_RST_WAIT_LINK: begin
          if (link_cfg_written || link_seen) begin
            rst_state <= emss_pkg::EMSS_RST_IDLE;
          end
        end
        default: rst_state <= emss_pkg::EMSS_RST_IDLE;
      endcase
    end
  end
  assign soft_reset_bit_out = (rst_state != emss_pkg::EMSS_RST_IDLE);
  assign mac_core_reset_out = (rst_state == emss_pkg::EMSS_RST_CORE);

  // gate control list storage
  logic [TW-1:0] row_int [DEPTH];
  logic [GW-1:0] row_gate [DEPTH];
  always_ff @(posedge core_clk_in) begin
    if (gcl_wr_in) begin
      row_int[gcl_wr_addr_in] <= gate_row_interval_in;
      row_gate[gcl_wr_addr_in] <= gcl_gates_in;
    end
  end

  // sum of valid row intervals
  function automatic logic [TW-1:0] list_sum(input logic [LW-1:0] len);
    logic [TW-1:0] s;
    s = '0;
    for (int i = 0; i < DEPTH; i++) begin
      if (LW'(i) < len) begin
        s = s + row_int[i];
      end
    end
    return s;
  endfunction

  emss_pkg::emss_gcl_state_t gcl_state;
  logic [RW-1:0] row;
  logic [TW-1:0] loop_base;
  logic [TW-1:0] row_end;
  logic [GW-1:0] gates;
  logic [15:0] loops;
  logic [TW-1:0] exec_time;
  wire sched_on = scheduled_traffic_enh_in && !soft_reset_bit_out && (gcl_length_in != '0);
  wire [TW-1:0] cycle_end = loop_base + cycle_time_value_in;
  wire cycle_hit = (ptp_time_in - loop_base) >= cycle_time_value_in;
  wire row_hit = (ptp_time_in - loop_base) >= (row_end - loop_base);
  wire last_row = (LW'(row) + 1'b1) >= gcl_length_in;
  wire [TW-1:0] next_row_end = row_end + row_int[RW'(row + 1'b1)];
  // leftover below the guard is still one loop: the base is advanced only on the cycle hit
  wire [TW-1:0] leftover = cycle_end - row_end;
  wire short_leftover = (leftover < MIN_LEFT);

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gcl_state <= emss_pkg::EMSS_GCL_OFF;
      row <= '0;
      loop_base <= '0;
      row_end <= '0;
      gates <= `EMSS_GATES_RESET;
      loops <= '0;
      exec_time <= '0;
    end else if (!sched_on) begin
      gcl_state <= emss_pkg::EMSS_GCL_OFF;
      gates <= `EMSS_GATES_RESET;
    end else begin
      case (gcl_state)
        emss_pkg::EMSS_GCL_OFF: begin
          loop_base <= base_time_value_in;
          loops <= '0;
          gcl_state <= emss_pkg::EMSS_GCL_WAIT_BASE;
        end
        emss_pkg::EMSS_GCL_WAIT_BASE: begin
          if ($signed(ptp_time_in - loop_base) >= 0) begin
            row <= '0;
            row_end <= loop_base + row_int[0];
            gates <= row_gate[0];
            exec_time <= loop_base + list_sum(gcl_length_in);
            gcl_state <= emss_pkg::EMSS_GCL_RUN;
          end
        end
        emss_pkg::EMSS_GCL_RUN, emss_pkg::EMSS_GCL_HOLD: begin
          if (cycle_hit) begin
            loop_base <= cycle_end;
            loops <= loops + 16'h0001;
            row <= '0;
            row_end <= cycle_end + row_int[0];
            gates <= row_gate[0];
            exec_time <= cycle_end + list_sum(gcl_length_in);
            gcl_state <= emss_pkg::EMSS_GCL_RUN;
          end else if (gcl_state == emss_pkg::EMSS_GCL_RUN && row_hit) begin
            if (last_row || short_leftover) begin
              gcl_state <= emss_pkg::EMSS_GCL_HOLD;
            end else begin
              row <= row + 1'b1;
              row_end <= next_row_end;
              gates <= row_gate[RW'(row + 1'b1)];
            end
          end
        end
        default: gcl_state <= emss_pkg::EMSS_GCL_OFF;
      endcase
    end
  end
  assign gate_state_out = gates;
  assign loop_start_out = loop_base;
  assign gcl_exec_time_out = exec_time;
  assign loop_count_out = loops;

  // transmit path: queue fifo, then shaper gate on gate bit 0
  logic fq_valid;
  logic [8:0] fq_data;
  logic fq_ready;
  emss_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(tq_valid_in),
    .in_data_in({tq_last_in, tq_data_in}),
    .in_ready_out(tq_ready_out),
    .out_valid_out(fq_valid),
    .out_data_out(fq_data),
    .out_ready_in(fq_ready)
  );

  emss_pkg::emss_tx_state_t tx_state;
  logic signed [CW-1:0] credit;
  logic [3:0] gap_cnt;
  logic out_valid;
  logic [7:0] out_data;
  logic out_last;
  wire start_ok = gates[0] && !credit[CW-1] && !mac_core_reset_out;
  wire out_free = !out_valid || tx_ready_in;
  assign fq_ready = out_free && ((tx_state == emss_pkg::EMSS_TX_FRAME) ||
                    (tx_state == emss_pkg::EMSS_TX_IDLE && start_ok));
  wire byte_go = fq_valid && fq_ready;
  wire pending = fq_valid || out_valid;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_state <= emss_pkg::EMSS_TX_IDLE;
      credit <= '0;
      gap_cnt <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
      out_last <= 1'b0;
    end else begin
      if (byte_go) begin
        out_valid <= 1'b1;
        out_data <= fq_data[7:0];
        out_last <= fq_data[8];
      end else if (tx_ready_in) begin
        out_valid <= 1'b0;
      end
      case (tx_state)
        emss_pkg::EMSS_TX_IDLE: begin
          if (byte_go) begin
            credit <= credit - $signed(send_slope_in);
            tx_state <= fq_data[8] ? emss_pkg::EMSS_TX_GAP : emss_pkg::EMSS_TX_FRAME;
            gap_cnt <= IPG;
          end else if (pending) begin
            credit <= credit + $signed(idle_slope_in);
          end else if (credit > 0) begin
            credit <= '0;
          end
        end
        emss_pkg::EMSS_TX_FRAME: begin
          if (byte_go) begin
            credit <= credit - $signed(send_slope_in);
            if (fq_data[8]) begin
              tx_state <= emss_pkg::EMSS_TX_GAP;
              gap_cnt <= IPG;
            end
          end
        end
        emss_pkg::EMSS_TX_GAP: begin
          credit <= credit + $signed(idle_slope_in);
          if (gap_cnt <= 4'h1) begin
            tx_state <= emss_pkg::EMSS_TX_IDLE;
          end else begin
            gap_cnt <= gap_cnt - 4'h1;
          end
        end
        default: tx_state <= emss_pkg::EMSS_TX_IDLE;
      endcase
    end
  end
  assign credit_out = credit;
  assign tx_valid_out = out_valid;
  assign tx_data_out = out_data;
  assign tx_last_out = out_last;
endmodule

/* File: verification/emss_top_asserts.sv */
// port assertions for the scheduling and shaping block
// assumes it is bound into emss_top and sees one clock domain
module emss_top_asserts #(
  parameter int TW = 32,
  parameter int CW = 32
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic soft_reset_set_in,
  input wire logic rmii_mode_in,
  input wire logic soft_reset_bit_out,
  input wire logic mac_core_reset_out,
  input wire logic scheduled_traffic_enh_in,
  input wire logic [TW-1:0] cycle_time_value_in,
  input wire logic [TW-1:0] ptp_time_in,
  input wire logic [TW-1:0] loop_start_out,
  input wire logic [15:0] loop_count_out,
  input wire logic [CW-1:0] idle_slope_in,
  input wire logic signed [CW-1:0] credit_out,
  input wire logic tx_valid_out,
  input wire logic tx_ready_in,
  input wire logic tx_last_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  wire logic tx_end = tx_valid_out && tx_ready_in && tx_last_out;
  a_srst_starts: assert property (soft_reset_set_in && !soft_reset_bit_out
    |=> soft_reset_bit_out && mac_core_reset_out) else $error("soft reset did not start");
  a_srst_holds: assert property ($rose(soft_reset_bit_out) |-> soft_reset_bit_out[*8])
    else $error("soft reset bit dropped early");
  a_srst_clears: assert property ($fell(mac_core_reset_out) && !rmii_mode_in |=> !soft_reset_bit_out)
    else $error("soft reset bit did not clear");
  a_loop_step: assert property (loop_count_out == $past(loop_count_out) + 16'h1
    && $past(loop_count_out) != 16'h0
    |-> loop_start_out == $past(loop_start_out) + $past(cycle_time_value_in))
    else $error("loop start off by cycle");
  a_single_adv: assert property ($changed(loop_count_out) |=> $stable(loop_count_out))
    else $error("loop advanced twice");
  a_cycle_bound: assert property (scheduled_traffic_enh_in && loop_count_out != 16'h0
    |-> ptp_time_in - loop_start_out <= cycle_time_value_in + 3) else $error("list ran past cycle end");
  a_frame_debit: assert property (tx_valid_out && $past(tx_valid_out) && !$past(tx_end)
    |-> credit_out <= $past(credit_out)) else $error("credit grew inside a frame");
  a_gap_credit: assert property (tx_end |-> ##[1:3] credit_out == $past(credit_out) + $signed(idle_slope_in))
    else $error("no credit after frame end");
  cover property ($fell(soft_reset_bit_out));
  cover property (loop_count_out == 16'h3);
  cover property (tx_end);
endmodule
bind emss_top emss_top_asserts #(.TW(TW), .CW(CW)) u_asserts (
  .core_clk_in(core_clk_in),
  .rst_n_in(rst_n_in),
  .soft_reset_set_in(soft_reset_set_in),
  .rmii_mode_in(rmii_mode_in),
  .soft_reset_bit_out(soft_reset_bit_out),
  .mac_core_reset_out(mac_core_reset_out),
  .scheduled_traffic_enh_in(scheduled_traffic_enh_in),
  .cycle_time_value_in(cycle_time_value_in),
  .ptp_time_in(ptp_time_in),
  .loop_start_out(loop_start_out),
  .loop_count_out(loop_count_out),
  .idle_slope_in(idle_slope_in),
  .credit_out(credit_out),
  .tx_valid_out(tx_valid_out),
  .tx_ready_in(tx_ready_in),
  .tx_last_out(tx_last_out)
);

/* File: verification/emss_phy_model.sv */
// phy side model: accepts transmit bytes, stalls while told to, checks byte order
// assumes the bench changes stall_in away from the rising edge
module emss_phy_model (
  input wire logic clk_in,
  input wire logic stall_in,
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_last_in,
  output logic tx_ready_out,
  output int n_rx_out,
  output int n_bad_out,
  output logic last_seen_out
);
  timeunit 1ns;
  timeprecision 1ps;
  assign tx_ready_out = !stall_in;
  initial begin
    n_rx_out = 0;
    n_bad_out = 0;
    last_seen_out = 1'h0;
  end
  // bytes are expected to carry their own index, so a lost or doubled byte shows
  always @(posedge clk_in) begin
    if (tx_valid_in && tx_ready_out) begin
      if (tx_data_in !== n_rx_out[7:0]) n_bad_out <= n_bad_out + 1;
      n_rx_out <= n_rx_out + 1;
      last_seen_out <= tx_last_in;
    end
  end
endmodule

/* File: verification/emss_top_test.sv */
// self-checking bench for the scheduling and shaping block
// assumes emss_top, its fifo and the phy model are compiled first
module emss_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, srst = 0, rmii = 0, ps = 0, fs = 0, enh = 0, wr = 0;
  logic tq_valid = 0, tq_last = 0, stall = 1;
  logic [31:0] base = 0, cyc = 0, ival = 0, ptp = 0, islope = 0, sslope = 0;
  logic signed [31:0] lo = 0;
  logic [3:0] len = 0;
  logic [2:0] waddr = 0;
  logic [7:0] gates = 0, tq_data = 0;
  wire logic srst_bit, core_rst, tq_ready, tx_valid, tx_last, tx_ready, phy_last;
  wire logic [7:0] gate_st, tx_data;
  wire logic [31:0] lstart, exec_t, credit;
  wire logic [15:0] lcount;
  int n_rx, n_bad, err_count = 0, n_compared = 0, cyc_n = 0;
  emss_top i_dut (.core_clk_in(clk), .rst_n_in(rst_n), .soft_reset_set_in(srst), .rmii_mode_in(rmii),
    .port_select_bit_in(ps), .speed_select_bit_in(fs), .soft_reset_bit_out(srst_bit), .mac_core_reset_out(core_rst),
    .scheduled_traffic_enh_in(enh), .base_time_value_in(base), .cycle_time_value_in(cyc), .gcl_length_in(len),
    .gcl_wr_in(wr), .gcl_wr_addr_in(waddr), .gate_row_interval_in(ival), .gcl_gates_in(gates), .ptp_time_in(ptp),
    .gate_state_out(gate_st), .loop_start_out(lstart), .gcl_exec_time_out(exec_t), .loop_count_out(lcount),
    .idle_slope_in(islope), .send_slope_in(sslope), .credit_out(credit), .tq_valid_in(tq_valid),
    .tq_data_in(tq_data), .tq_last_in(tq_last), .tq_ready_out(tq_ready), .tx_valid_out(tx_valid),
    .tx_data_out(tx_data), .tx_last_out(tx_last), .tx_ready_in(tx_ready));
  emss_phy_model i_phy (.clk_in(clk), .stall_in(stall), .tx_valid_in(tx_valid), .tx_data_in(tx_data),
    .tx_last_in(tx_last), .tx_ready_out(tx_ready), .n_rx_out(n_rx), .n_bad_out(n_bad), .last_seen_out(phy_last));
  initial forever #20 clk = ~clk;
  // ptp time ticks 1 ns per core cycle so short leftovers are reachable
  always @(negedge clk) ptp <= ptp + 32'h1;
  always @(negedge clk) if ($signed(credit) < lo) lo <= $signed(credit);
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 5000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic do_reset();
    @(negedge clk);
    rst_n = 0;
    enh = 0;
    repeat (3) @(negedge clk);
    rst_n = 1;
  endtask
  task automatic t_srst(input logic mode);
    int i;
    rmii = mode;
    srst = 1;
    @(negedge clk);
    srst = 0;
    check(srst_bit, 1'h1);
    check(core_rst, 1'h1);
    repeat (14) @(negedge clk);
    check(srst_bit, mode);
    check(core_rst, 1'h0);
    if (mode) begin
      ps = ~ps;
      fs = ~fs;
    end
    for (i = 0; i < 8 && srst_bit !== 1'h0; i++) @(negedge clk);
    check(srst_bit, 1'h0);
  endtask
  task automatic t_sched(input logic [31:0] c, input logic [31:0] iv);
    logic [31:0] st [3];
    logic [15:0] n0;
    int i, k;
    do_reset();
    cyc = c;
    ival = iv;
    len = 4'h3;
    for (i = 0; i < 3; i++) begin
      wr = 1;
      waddr = i[2:0];
      gates = 8'h11 << i[2:0];
      @(negedge clk);
    end
    wr = 0;
    base = ptp + 32'h14;
    enh = 1;
    for (k = 0; k < 3; k++) begin
      n0 = lcount;
      for (i = 0; i < 300 && lcount === n0; i++) @(negedge clk);
      check(lcount, n0 + 16'h1);
      st[k] = lstart;
      check(lstart, base + (k + 1) * c);
      repeat (2) @(negedge clk);
      check(gate_st, 8'h11);
      check(exec_t, base + (k + 1) * c + 3 * iv);
      repeat (iv) @(negedge clk);
      check(gate_st, 8'h22);
    end
    check(st[1] - st[0], c);
    check(st[2] - st[1], c);
  endtask
  task automatic t_shaper();
    int n, i;
    do_reset();
    islope = 32'h2;
    sslope = 32'h3;
    stall = 1;
    tq_valid = 1;
    // fill while the phy stalls until the fifo refuses
    for (n = 0; n < 40; n++) begin
      tq_data = n[7:0];
      if (tq_ready !== 1'h1) break;
      @(negedge clk);
    end
    tq_valid = 0;
    check(n, 32'h21);
    stall = 0;
    for (i = 0; i < 10 && tq_ready !== 1'h1; i++) @(negedge clk);
    tq_data = n[7:0];
    tq_last = 1;
    tq_valid = 1;
    @(negedge clk);
    tq_valid = 0;
    tq_last = 0;
    for (i = 0; i < 200 && n_rx < n + 1; i++) @(negedge clk);
    repeat (4) @(negedge clk);
    check(n_rx, n + 1);
    check(n_bad, 0);
    check(phy_last, 1'h1);
    check(lo, -3 * (n + 1));
  endtask
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1;
    t_srst(1'h0);
    t_srst(1'h1);
    t_sched(32'h2d, 32'hf);
    t_sched(32'h32, 32'hf);
    t_sched(32'h1e, 32'hf);
    t_shaper();
    finish_test();
  end
endmodule
